// ===== ccrs_top.sv
// core clock divider, reset synchroniser and reset-time bus grant
`timescale 1ns/1ps
`include "ccrs_params.svh"

module ccrs_top (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic osc_in_pin,
    input  wire logic system_clear_request_n,
    input  wire logic bus_grant_request,
    output logic      osc_out_pin,
    output logic      core_clock_out,
    output logic      system_reset,
    output logic      phase_realign_pulse,
    output logic      bus_active,
    output logic      bus_grant_ack,
    output logic      prefetch_enable
);

    ccrs_pkg::ccrs_pins_t  pins_raw;
    ccrs_pkg::ccrs_pins_t  pins;
    logic                  osc_prev_r;
    logic                  osc_prev_nxt;
    logic                  osc_fall;
    logic                  req_smp_r;
    logic                  req_smp_nxt;
    logic                  smp_fall;
    logic                  smp_rise;
    logic                  core_clock_out_r;
    logic                  core_clock_out_nxt;
    logic                  skip_r;
    logic                  skip_nxt;
    logic                  arm_r;
    logic                  arm_nxt;
    logic                  pulse_r;
    logic                  pulse_nxt;
    logic                  osc_out_r;
    logic                  osc_out_nxt;
    logic                  clk_fall;
    ccrs_pkg::ccrs_state_t state_r;
    ccrs_pkg::ccrs_state_t state_nxt;
    logic [1:0]            fall_cnt_r;
    logic [1:0]            fall_cnt_nxt;
    logic                  sysrst_r;
    logic                  sysrst_nxt;
    logic [3:0]            half_cnt_r;
    logic [3:0]            half_cnt_nxt;
    logic                  counting_r;
    logic                  counting_nxt;
    logic                  bus_r;
    logic                  bus_nxt;

    // pins pass the three stage synchroniser
    assign pins_raw.osc_in_pin             = osc_in_pin;
    assign pins_raw.system_clear_request_n = system_clear_request_n;
    assign pins_raw.bus_grant_request      = bus_grant_request;

    ccrs_pin_sync #(
        .WIDTH     (`CCRS_PIN_WIDTH),
        .RESET_VAL (`CCRS_PIN_RESET_VAL)
    ) u_sync (
        .clk       (clk),
        .rst       (rst),
        .pin_in    (pins_raw),
        .level_out (pins)
    );

    // oscillator falling edge detect and request sampling
    always_comb begin
        osc_prev_nxt = pins.osc_in_pin;
        osc_fall     = osc_prev_r & ~pins.osc_in_pin;
        req_smp_nxt  = osc_fall ? pins.system_clear_request_n : req_smp_r;
        smp_fall     = osc_fall & req_smp_r & ~pins.system_clear_request_n;
        smp_rise     = osc_fall & ~req_smp_r & pins.system_clear_request_n;
        pulse_nxt    = smp_fall;
        osc_out_nxt  = ~pins.osc_in_pin;                                    // inverter image
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            osc_prev_r <= 1'b0;
            req_smp_r  <= 1'b0;
            pulse_r    <= 1'b0;
            osc_out_r  <= 1'b1;
        end else begin
            osc_prev_r <= osc_prev_nxt;
            req_smp_r  <= req_smp_nxt;
            pulse_r    <= pulse_nxt;
            osc_out_r  <= osc_out_nxt;
        end
    end

    // divide by two with phase realignment on reset exit
    always_comb begin
        core_clock_out_nxt = core_clock_out_r;
        skip_nxt   = skip_r;
        arm_nxt    = arm_r | pulse_r;
        if (osc_fall) begin
            if (skip_r) begin
                skip_nxt = 1'b0;                            // second low cycle
            end else if (smp_rise && arm_r && core_clock_out_r) begin
                core_clock_out_nxt = 1'b0;                          // skip a beat
                skip_nxt   = 1'b1;
                arm_nxt    = 1'b0;
            end else begin
                core_clock_out_nxt = ~core_clock_out_r;
                if (smp_rise) begin
                    arm_nxt = 1'b0;                         // already in phase
                end
            end
        end
    end

    assign clk_fall = osc_fall & core_clock_out_r & ~core_clock_out_nxt;

    // divider keeps running in reset and hold; state held if oscillator stops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            core_clock_out_r <= 1'b0;
            skip_r   <= 1'b0;
            arm_r    <= 1'b1;
        end else begin
            core_clock_out_r <= core_clock_out_nxt;
            skip_r   <= skip_nxt;
            arm_r    <= arm_nxt;
        end
    end

    // reset sequencer
    always_comb begin
        state_nxt    = state_r;
        fall_cnt_nxt = fall_cnt_r;
        sysrst_nxt   = sysrst_r;
        case (state_r)
            ccrs_pkg::CCRS_RUN: begin
                if (osc_fall && !pins.system_clear_request_n) begin
                    state_nxt    = ccrs_pkg::CCRS_ASSERT;   // first fall sampled low
                    fall_cnt_nxt = 2'h1;
                end
            end
            ccrs_pkg::CCRS_ASSERT: begin
                if (osc_fall) begin
                    if (pins.system_clear_request_n) begin
                        state_nxt    = ccrs_pkg::CCRS_RUN;  // too short a request
                        fall_cnt_nxt = 2'h0;
                    end else if (fall_cnt_r + 2'h1 == `CCRS_ASSERT_FALLS) begin
                        state_nxt    = ccrs_pkg::CCRS_HELD;
                        sysrst_nxt   = 1'b1;
                        fall_cnt_nxt = 2'h0;
                    end else begin
                        fall_cnt_nxt = fall_cnt_r + 2'h1;
                    end
                end
            end
            ccrs_pkg::CCRS_HELD: begin
                sysrst_nxt = 1'b1;
                if (smp_rise) begin
                    state_nxt    = ccrs_pkg::CCRS_RELEASE;
                    fall_cnt_nxt = 2'h0;
                end
            end
            ccrs_pkg::CCRS_RELEASE: begin
                if (osc_fall && !pins.system_clear_request_n) begin
                    state_nxt    = ccrs_pkg::CCRS_HELD;     // request back low
                    fall_cnt_nxt = 2'h0;
                end else if (clk_fall) begin
                    if (fall_cnt_r + 2'h1 == `CCRS_RELEASE_FALLS) begin
                        state_nxt    = ccrs_pkg::CCRS_RUN;
                        sysrst_nxt   = 1'b0;                // release on core fall
                        fall_cnt_nxt = 2'h0;
                    end else begin
                        fall_cnt_nxt = fall_cnt_r + 2'h1;
                    end
                end
            end
            default: begin
                state_nxt    = ccrs_pkg::CCRS_HELD;
                sysrst_nxt   = 1'b1;
                fall_cnt_nxt = 2'h0;
            end
        endcase
    end

    // cold start enters held reset at once
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r    <= ccrs_pkg::CCRS_HELD;
            fall_cnt_r <= 2'h0;
            sysrst_r   <= 1'b1;
        end else begin
            state_r    <= state_nxt;
            fall_cnt_r <= fall_cnt_nxt;
            sysrst_r   <= sysrst_nxt;
        end
    end

    // bus start delay counted in core clock half periods
    always_comb begin
        half_cnt_nxt = half_cnt_r;
        counting_nxt = counting_r;
        bus_nxt      = bus_r;
        if (sysrst_nxt && state_nxt != ccrs_pkg::CCRS_RELEASE) begin
            half_cnt_nxt = 4'h0;                            // reset stops the bus
            counting_nxt = 1'b0;
            bus_nxt      = 1'b0;
        end else if (smp_rise && state_r == ccrs_pkg::CCRS_HELD) begin
            half_cnt_nxt = 4'h0;                            // request seen high
            counting_nxt = 1'b1;
        end else if (counting_r && osc_fall && (core_clock_out_nxt != core_clock_out_r)) begin
            if (half_cnt_r + 4'h1 == `CCRS_BUS_START_HALVES) begin
                counting_nxt = 1'b0;
                bus_nxt      = 1'b1;
                half_cnt_nxt = 4'h0;
            end else begin
                half_cnt_nxt = half_cnt_r + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            half_cnt_r <= 4'h0;
            counting_r <= 1'b0;
            bus_r      <= 1'b0;
        end else begin
            half_cnt_r <= half_cnt_nxt;
            counting_r <= counting_nxt;
            bus_r      <= bus_nxt;
        end
    end

    // outputs
    assign osc_out_pin         = osc_out_r;
    assign core_clock_out      = core_clock_out_r;
    assign system_reset        = sysrst_r;
    assign phase_realign_pulse = pulse_r;
    assign bus_active          = bus_r;
    assign bus_grant_ack       = sysrst_r & pins.bus_grant_request;
    assign prefetch_enable     = bus_r & ~bus_grant_ack;             // no prefetch in hold

endmodule : ccrs_top

// ===== ccrs_params.svh
// timing counts and reset values for the clock divide and reset sync block
`ifndef CCRS_PARAMS_SVH
`define CCRS_PARAMS_SVH

// synchroniser depth for pin inputs
`define CCRS_SYNC_STAGES        3
// pin inputs: {bus_grant_request, system_clear_request_n, osc_in_pin}
`define CCRS_PIN_WIDTH          3
// idle levels of the pin synchronisers: request asserted, osc and grant low
`define CCRS_PIN_RESET_VAL      3'h0
// core clock half periods from request seen high to first bus activity
`define CCRS_BUS_START_HALVES   4'hd
// core clock falling edges from request seen high to reset release
`define CCRS_RELEASE_FALLS      2'h2
// oscillator falling edges from request sampled low to pins in reset
`define CCRS_ASSERT_FALLS       2'h2

`endif

// ===== ccrs_pkg.sv
// types shared by the clock divide and reset sync block
package ccrs_pkg;

    // synchronised pin levels, grouped
    typedef struct packed {
        logic bus_grant_request;
        logic system_clear_request_n;
        logic osc_in_pin;
    } ccrs_pins_t;

    // reset sequencer states, gray coded along run, assert, held, release
    typedef enum logic [1:0] {
        CCRS_RUN     = 2'h0,
        CCRS_ASSERT  = 2'h1,
        CCRS_HELD    = 2'h3,
        CCRS_RELEASE = 2'h2
    } ccrs_state_t;

endpackage : ccrs_pkg

// ===== ccrs_pin_sync.sv
// three stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`include "ccrs_params.svh"

module ccrs_pin_sync #(
    parameter int                   WIDTH     = `CCRS_PIN_WIDTH,
    parameter logic [WIDTH-1:0]     RESET_VAL = `CCRS_PIN_RESET_VAL
) (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic [WIDTH-1:0]   pin_in,
    output logic      [WIDTH-1:0]   level_out
);

    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] level_r;
    logic [WIDTH-1:0] level_nxt;

    // accept a change once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_comb begin
                level_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : level_r[g];
            end
        end
    endgenerate

    // shift chain and filtered level
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_r    <= RESET_VAL;
            s2_r    <= RESET_VAL;
            s3_r    <= RESET_VAL;
            level_r <= RESET_VAL;
        end else begin
            s1_r    <= pin_in;
            s2_r    <= s1_r;
            s3_r    <= s2_r;
            level_r <= level_nxt;
        end
    end

    assign level_out = level_r;

endmodule : ccrs_pin_sync

// ===== ccrs_monitor.sv
// port assertions for the clock divide and reset sync top
`timescale 1ns/1ps
module ccrs_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic osc_in_pin,
    input wire logic system_clear_request_n,
    input wire logic bus_grant_request,
    input wire logic osc_out_pin,
    input wire logic core_clock_out,
    input wire logic system_reset,
    input wire logic phase_realign_pulse,
    input wire logic bus_active,
    input wire logic bus_grant_ack,
    input wire logic prefetch_enable
);
    logic [3:0] low_r;
    logic [3:0] low_nxt;
    // cycles the raw request has stayed low, saturating
    always_comb begin
        low_nxt = system_clear_request_n ? 4'h0 : low_r + {3'h0, low_r != 4'hf};
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_r <= 4'h0;
        end else begin
            low_r <= low_nxt;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_half; $changed(core_clock_out) |=> $stable(core_clock_out)[*5]; endproperty
    a_half: assert property (p_half) else $error("core clock toggled too soon");
    property p_fall; $fell(osc_in_pin) && core_clock_out |-> ##[3:6] !core_clock_out; endproperty
    a_fall: assert property (p_fall) else $error("core clock missed osc fall");
    property p_pulse_on; $fell(system_clear_request_n) |-> ##[1:16] phase_realign_pulse; endproperty
    a_pulse_on: assert property (p_pulse_on) else $error("no realign pulse");
    property p_pulse_one; phase_realign_pulse |=> !phase_realign_pulse; endproperty
    a_pulse_one: assert property (p_pulse_one) else $error("realign pulse too long");
    property p_assert; phase_realign_pulse |-> ##[1:12] system_reset; endproperty
    a_assert: assert property (p_assert) else $error("reset not applied");
    property p_hold; system_reset && low_r > 4'h5 |=> system_reset; endproperty
    a_hold: assert property (p_hold) else $error("reset dropped while requested");
    property p_release; $fell(system_reset) |-> $fell(core_clock_out); endproperty
    a_release: assert property (p_release) else $error("release off clock fall");
    property p_bus; $fell(system_reset) |-> ##[68:84] $rose(bus_active); endproperty
    a_bus: assert property (p_bus) else $error("bus start mistimed");
    property p_ack; bus_grant_ack |-> system_reset; endproperty
    a_ack: assert property (p_ack) else $error("ack outside reset");
    property p_ack_on; (system_reset && bus_grant_request)[*6] |-> bus_grant_ack; endproperty
    a_ack_on: assert property (p_ack_on) else $error("grant not acked");
    property p_pref; prefetch_enable |-> bus_active && !bus_grant_ack; endproperty
    a_pref: assert property (p_pref) else $error("prefetch while held");
    c_warm: cover property ($rose(system_reset));
    c_bus: cover property ($rose(bus_active));
    c_ack: cover property ($rose(bus_grant_ack));
endmodule : ccrs_monitor

bind ccrs_top ccrs_monitor u_mon (.clk(clk), .rst(rst), .osc_in_pin(osc_in_pin),
    .system_clear_request_n(system_clear_request_n), .bus_grant_request(bus_grant_request),
    .osc_out_pin(osc_out_pin), .core_clock_out(core_clock_out), .system_reset(system_reset),
    .phase_realign_pulse(phase_realign_pulse), .bus_active(bus_active),
    .bus_grant_ack(bus_grant_ack), .prefetch_enable(prefetch_enable));

// ===== ccrs_src_model.sv
// oscillator source and reset requester facing the block
`timescale 1ns/1ps
module ccrs_src_model #(
    parameter int HALF    = 4,
    parameter int MIN_LOW = 64
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic stall,
    input wire logic req_cmd_n,
    output logic     osc_in_pin,
    output logic     system_clear_request_n
);
    int half_cnt;
    int low_cnt;
    // stoppable oscillator wired straight to the input pin
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            osc_in_pin <= 1'b0;
            half_cnt <= 0;
        end else if (!stall && half_cnt == HALF - 1) begin
            half_cnt <= 0;
            osc_in_pin <= !osc_in_pin;
        end else if (!stall) begin
            half_cnt <= half_cnt + 1;
        end
    end
    // request low through startup, then kept low four core periods
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            system_clear_request_n <= 1'b0;
            low_cnt <= 0;
        end else if (!system_clear_request_n && low_cnt < MIN_LOW) begin
            low_cnt <= low_cnt + 1;
        end else begin
            system_clear_request_n <= req_cmd_n;
            // count restarts only once the request is high again
            if (system_clear_request_n) begin
                low_cnt <= 0;
            end
        end
    end
endmodule : ccrs_src_model

// ===== test_clock_divide_and_reset_sync.sv
// self-checking bench for the clock divide and reset sync block
`timescale 1ns/1ps
module test_clock_divide_and_reset_sync;
    logic clk, rst, stall, req_cmd_n, grant, osc, req_n;
    logic core_clk, sys_rst, pulse, bus_act, ack, pref, held, osc_img;
    int   bad_count, checks, cyc, n_pulse, n0, t0, hi, lo;
    ccrs_src_model u_src (.clk(clk), .rst(rst), .stall(stall), .req_cmd_n(req_cmd_n),
        .osc_in_pin(osc), .system_clear_request_n(req_n));
    ccrs_top dut (.clk(clk), .rst(rst), .osc_in_pin(osc), .system_clear_request_n(req_n),
        .bus_grant_request(grant), .osc_out_pin(osc_img), .core_clock_out(core_clk),
        .system_reset(sys_rst), .phase_realign_pulse(pulse), .bus_active(bus_act),
        .bus_grant_ack(ack), .prefetch_enable(pref));
    // clock source
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // cycle ceiling and pulse tally
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (pulse === 1'b1) n_pulse <= n_pulse + 1;
        if (cyc == 20000) begin
            bad_count++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    // watched signal: 0 core clock, 1 bus active, else raw request
    function automatic logic pick(input int sel);
        case (sel)
            0: return core_clk;
            1: return bus_act;
            default: return req_n;
        endcase
    endfunction : pick
    task automatic wait_for(input int sel, input logic val);
        repeat (400) begin
            @(negedge clk);
            if (pick(sel) === val) return;
        end
        chk("wait", {15'h0, val}, {15'h0, pick(sel)});
    endtask : wait_for
    // high and low time of one core clock period
    task automatic core_period();
        wait_for(0, 1'b0);
        wait_for(0, 1'b1);
        t0 = cyc;
        wait_for(0, 1'b0);
        hi = cyc - t0;
        t0 = cyc;
        wait_for(0, 1'b1);
        lo = cyc - t0;
    endtask : core_period
    // bus start lies 13 core half periods after the high sample, plus pin latency
    function automatic logic [15:0] in_win(input int t);
        return {15'h0, t >= 13 * 8 && t <= 13 * 8 + 20};
    endfunction : in_win
    initial begin
        rst = 1'b1;
        stall = 1'b0;
        req_cmd_n = 1'b0;
        grant = 1'b0;
        {cyc, bad_count, checks, n_pulse} = '0;
        void'($urandom(56013));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        // held reset after power up with an alternate master asking
        @(posedge clk) grant <= 1'b1;
        repeat (8) @(negedge clk);
        chk("ack in reset", 16'h1, {15'h0, ack});
        chk("prefetch in reset", 16'h0, {15'h0, pref});
        chk("reset held", 16'h1, {15'h0, sys_rst});
        core_period();
        chk("high time in reset", 16'h8, 16'(hi));
        chk("low time in reset", 16'h8, 16'(lo));
        @(posedge clk) grant <= 1'b0;
        // cold exit, then warm resets at random clock phases
        for (int i = 0; i < 5; i++) begin
            if (i > 0) begin
                repeat ($urandom_range(15)) @(posedge clk);
                req_cmd_n <= 1'b0;
                grant <= 1'($urandom_range(1));
                n0 = n_pulse;
                repeat (24) @(negedge clk);
                chk("pins in reset", 16'h1, {15'h0, sys_rst});
                chk("grant ack", {15'h0, grant}, {15'h0, ack});
                chk("realign pulses", 16'h1, 16'(n_pulse - n0));
                repeat (48 + $urandom_range(60)) @(posedge clk);
                grant <= 1'b0;
            end
            @(posedge clk) req_cmd_n <= 1'b1;
            wait_for(2, 1'b1);
            t0 = cyc;
            wait_for(1, 1'b1);
            chk("bus start", 16'h1, in_win(cyc - t0));
            chk("reset released", 16'h0, {15'h0, sys_rst});
            chk("prefetch", 16'h1, {15'h0, pref});
        end
        // oscillator stopped and resumed with state kept
        @(posedge clk) stall <= 1'b1;
        grant <= 1'b1;
        repeat (8) @(negedge clk);
        held = core_clk;
        repeat (60) @(negedge clk);
        chk("core clock stopped", {15'h0, held}, {15'h0, core_clk});
        chk("osc image", {15'h0, ~osc}, {15'h0, osc_img});
        chk("still running", 16'h1, {15'h0, bus_act});
        chk("ack outside reset", 16'h0, {15'h0, ack});
        @(posedge clk) stall <= 1'b0;
        core_period();
        chk("high time resumed", 16'h8, 16'(hi));
        give_verdict();
    end
endmodule : test_clock_divide_and_reset_sync
